// file: common/ncp_pkg.sv
// constants shared by the nibble command port design
// Summary of operation
// R1: address byte: bit7 set, bit6 read, 5:0 register
// R2: write address is followed by nibble pairs
// R3: new address drops pending address and nibble
// R4: data byte: bit7 clear, low nibble carries data
// R5: first nibble upper half, second lower half
// R6: byte series: each byte is its own pair
// R7: master starts only when selected and ready high
// R8: ready drops after each byte, rises later
// R9: lower nibble completes and stores the byte
// R10: read request answered on interrupt and data bus
// R11: events wait while a read is outstanding
// R12: 500 byte descriptor memory behind register 0x30
// R13: length low then high, then descriptor bytes
// R14: detach pull-up, parse, reattach after load
// R15: enumeration done raises an event
// R16: master orders the descriptors in standard order
// R17: chirp value 0x02 forces full speed only
// R18: unindexed write: register, upper, lower nibble
// R19: unindexed pointer via 0x3a, 0x3b, data via 0x3c
// R20: length six selects the built in descriptor
// R21: identifiers sent low byte first
// R22: commands use only the low eight data lines
// R23: release interrupt after read, then show events
package ncp_pkg;
	localparam logic [2:0]  NCP_SEL_CMD     = 3'h4;
	localparam int          NCP_ADDR_BIT    = 7;
	localparam int          NCP_RD_BIT      = 6;
	localparam int          NCP_CHIRP_FS    = 1;
	localparam logic [5:0]  NCP_REG_IFSETUP = 6'h01;
	localparam logic [5:0]  NCP_REG_DESC    = 6'h30;
	localparam logic [5:0]  NCP_REG_UPTR_LO = 6'h3a;
	localparam logic [5:0]  NCP_REG_UPTR_HI = 6'h3b;
	localparam logic [5:0]  NCP_REG_UDATA   = 6'h3c;
	localparam logic [15:0] NCP_CHIRP_ADDR  = 16'he6fb;
	localparam logic [7:0]  NCP_IFSETUP_RST = 8'h00;
	localparam logic [7:0]  NCP_CHIRP_RST   = 8'h00;
	localparam int          NCP_DESC_BYTES  = 500;
	localparam int          NCP_MEM_AW      = 9;
	localparam logic [15:0] NCP_DEFAULT_LEN = 16'h0006;
	localparam int          NCP_EVENTS      = 6;
	localparam int          NCP_EV_ENUM     = 0;
	// timing: figures in ns, counts derived from the clock period
	localparam int          NCP_CLK_NS      = 25;
	localparam int          NCP_HOLD_NS     = 75;
	localparam int          NCP_HOLD_CYC    =
		(NCP_HOLD_NS + NCP_CLK_NS - 1) / NCP_CLK_NS;
	localparam int          NCP_DETACH_NS   = 10000;
	localparam int          NCP_DETACH_CYC  =
		(NCP_DETACH_NS + NCP_CLK_NS - 1) / NCP_CLK_NS;
	localparam int          NCP_TMR_W       = 12;
	typedef enum logic [1:0] {ncp_idle, ncp_hi, ncp_lo} ncp_cmd_t;
	typedef enum logic [2:0] {ncp_en_idle, ncp_en_detach, ncp_en_parse,
		ncp_en_attach, ncp_en_run} ncp_enum_t;
endpackage

// file: core/ncp_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none
module ncp_sync #(
	parameter int           W       = 1,
	parameter logic [W-1:0] RST_VAL = '1
) (
	input  wire logic         ref_clk,
	input  wire logic         nrst,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] meta; // first stage, read only by the second
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			// reset to a constant idle level, so no false edge follows
			always_ff @(posedge ref_clk or negedge nrst) begin
				if (!nrst) begin
					meta[i] <= RST_VAL[i];
					dout[i] <= RST_VAL[i];
				end else begin
					meta[i] <= din[i];
					dout[i] <= meta[i];
				end
			end
		end
	endgenerate
endmodule
`default_nettype wire

// file: core/ncp_desc_mem.sv
// descriptor storage in flip-flops, one write port, one read port
`timescale 1ns/10ps
`default_nettype none
module ncp_desc_mem #(
	parameter int DEPTH = 500,
	parameter int AW    = 9,
	parameter int DW    = 8
) (
	input  wire logic          ref_clk,
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [DW-1:0] wdata,
	input  wire logic [AW-1:0] raddr,
	output logic      [DW-1:0] rdata
);
	logic [DW-1:0] mem [DEPTH]; // no reset: contents valid only once loaded
	// write port; addresses past the end are dropped
	always_ff @(posedge ref_clk) begin
		if (we && (int'(waddr) < DEPTH)) begin
			mem[waddr] <= wdata;
		end
	end
	// read port; out of range reads zero so a parse walk stops
	always_comb begin
		rdata = '0;
		if (int'(raddr) < DEPTH) begin
			rdata = mem[raddr];
		end
	end
endmodule
`default_nettype wire

// file: core/ncp_top.sv
// nibble command port: decoder, registers, read answer, enumeration
`timescale 1ns/10ps
`default_nettype none
module ncp_top
	import ncp_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       nrst,
	input  wire logic [2:0] port_select_lines,
	input  wire logic       wr_strobe_n,
	input  wire logic       rd_strobe_n,
	input  wire logic       out_enable_n,
	input  wire logic [7:0] shared_data_bus_in,
	input  wire logic [4:0] source_events,
	output logic      [7:0] shared_data_bus_out,
	output logic            shared_data_bus_oe,
	output logic            ready,
	output logic            int_n,
	output logic            dplus_pullup_en,
	output logic            full_speed_only,
	output logic            default_descriptor,
	output logic      [7:0] interface_setup,
	output logic      [7:0] descriptor_count
);
	////////////////////////////////////////////////////////////////////////
	// pin synchronisation and strobe edges
	logic [13:0] pins_s;      // synchronised pins
	logic [2:0]  sel_s;       // port select after sync
	logic        wr_s;        // write strobe after sync
	logic        rd_s;        // read strobe after sync
	logic        oe_s;        // output enable after sync
	logic [7:0]  rx;          // low data byte only
	logic        wr_d;        // delayed strobes for edge detection
	logic        rd_d;
	logic        sel_cmd;     // command port selected
	logic        byte_take;   // one accepted command byte
	logic        rd_take;     // master took the presented value
	// all pins reset high: strobes idle, port not selected
	ncp_sync #(.W(14), .RST_VAL('1)) u_sync (
		.ref_clk (ref_clk),
		.nrst    (nrst),
		.din     ({port_select_lines, wr_strobe_n, rd_strobe_n,
			out_enable_n, shared_data_bus_in}),
		.dout    (pins_s)
	);
	assign sel_s = pins_s[13:11];
	assign wr_s  = pins_s[10];
	assign rd_s  = pins_s[9];
	assign oe_s  = pins_s[8];
	assign rx    = pins_s[7:0]; // R22
	assign sel_cmd = (sel_s == NCP_SEL_CMD);
	// bytes arriving while ready is low are ignored, not queued
	assign byte_take = sel_cmd && !wr_s && wr_d && ready;
	assign rd_take   = sel_cmd && !rd_s && rd_d;
	// strobe history
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			wr_d <= 1'b1;
			rd_d <= 1'b1;
		end else begin
			wr_d <= wr_s;
			rd_d <= rd_s;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// command decoder, register file, descriptor loading
	ncp_cmd_t    state, next_state;
	logic [5:0]  addr, next_addr;         // target register number
	logic [3:0]  hi_nib, next_hi_nib;     // pending upper nibble
	logic [15:0] uptr, next_uptr;         // unindexed register pointer
	logic [7:0]  chirp_control, next_chirp_control;
	logic [7:0]  next_interface_setup;
	logic [15:0] desc_idx, next_desc_idx; // bytes taken on 0x30
	logic [15:0] desc_len, next_desc_len; // declared total length
	logic        rd_req;                  // read address byte seen
	logic        load_done;               // last descriptor byte stored
	logic        mem_we;
	logic [NCP_MEM_AW-1:0] mem_waddr;
	logic [7:0]  val;                     // assembled byte
	logic [15:0] stored;                  // bytes stored after this one
	ncp_enum_t   en_state, next_en_state;
	// next values of the decoder
	always_comb begin
		next_state = state;
		next_addr = addr;
		next_hi_nib = hi_nib;
		next_uptr = uptr;
		next_chirp_control = chirp_control;
		next_interface_setup = interface_setup;
		next_desc_idx = desc_idx;
		next_desc_len = desc_len;
		rd_req = 1'b0;
		load_done = 1'b0;
		mem_we = 1'b0;
		val = {hi_nib, rx[3:0]}; // R5
		stored = desc_idx - 16'h0001;
		mem_waddr = NCP_MEM_AW'(desc_idx - 16'h0002);
		if (byte_take) begin
			if (rx[NCP_ADDR_BIT]) begin // R1
				// any address restarts the sequence, dropping halves
				next_addr = rx[5:0]; // R3
				next_hi_nib = '0; // R3
				if (rx[NCP_RD_BIT]) begin
					next_state = ncp_idle;
					rd_req = 1'b1; // R10
				end else begin
					next_state = ncp_hi;
					if (rx[5:0] == NCP_REG_DESC) begin
						next_desc_idx = '0; // R13
					end
				end
			end else if (state == ncp_hi) begin // R4
				next_hi_nib = rx[3:0]; // R5
				next_state = ncp_lo;
			end else if (state == ncp_lo) begin
				// back to upper half: a register may take a series
				next_state = ncp_hi; // R6
				unique case (addr) // R9
					NCP_REG_IFSETUP: next_interface_setup = val;
					NCP_REG_UPTR_LO: next_uptr[7:0] = val; // R19
					NCP_REG_UPTR_HI: next_uptr[15:8] = val; // R19
					NCP_REG_UDATA: begin
						if (uptr == NCP_CHIRP_ADDR) begin
							next_chirp_control = val; // R17
						end
					end
					NCP_REG_DESC: begin
						// loading only before enumeration starts
						if (en_state == ncp_en_idle) begin // R12
							next_desc_idx = desc_idx + 16'h0001;
							if (desc_idx == 16'h0000) begin
								next_desc_len[7:0] = val; // R13
							end else if (desc_idx == 16'h0001) begin
								next_desc_len[15:8] = val; // R13
							end else begin
								mem_we = 1'b1; // R12
								load_done = (stored == desc_len);
							end
						end
					end
					default: begin
					end
				endcase
			end
		end
	end
	// decoder registers
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			state <= ncp_idle;
			addr <= '0;
			hi_nib <= '0;
			uptr <= '0;
			chirp_control <= NCP_CHIRP_RST;
			interface_setup <= NCP_IFSETUP_RST;
			desc_idx <= '0;
			desc_len <= '0;
		end else begin
			state <= next_state;
			addr <= next_addr;
			hi_nib <= next_hi_nib;
			uptr <= next_uptr;
			chirp_control <= next_chirp_control;
			interface_setup <= next_interface_setup;
			desc_idx <= next_desc_idx;
			desc_len <= next_desc_len;
		end
	end
	logic [NCP_MEM_AW-1:0] mem_raddr;
	logic [7:0]            mem_rdata;
	ncp_desc_mem #(
		.DEPTH (NCP_DESC_BYTES),
		.AW    (NCP_MEM_AW),
		.DW    (8)
	) u_mem (
		.ref_clk (ref_clk),
		.we      (mem_we),
		.waddr   (mem_waddr),
		.wdata   (val),
		.raddr   (mem_raddr),
		.rdata   (mem_rdata)
	);
	////////////////////////////////////////////////////////////////////////
	// ready hold-off after each accepted byte
	logic [3:0] hold, next_hold;
	logic       next_ready;
	always_comb begin
		next_hold = (hold != '0) ? hold - 4'h1 : hold;
		if (byte_take) begin
			next_hold = 4'(NCP_HOLD_CYC); // R8
		end
		next_ready = (next_hold == '0); // R8
	end
	// ready is low in reset and rises on the first clock edge after it, with no count-down
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			hold <= '0;
			ready <= 1'b0;
		end else begin
			hold <= next_hold;
			ready <= next_ready;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// read answer and event signalling on the interrupt line
	logic [5:0] pend, next_pend;   // events waiting to be shown
	logic [5:0] shown, next_shown; // events on the bus now
	logic       rd_busy, next_rd_busy;
	logic       gap, next_gap;     // one idle cycle after a read
	logic       enum_ev;           // enumeration done pulse
	logic [7:0] rd_val;
	logic [7:0] next_dout;
	logic       next_int_n;
	// register read mux; follows the address byte being taken now
	always_comb begin
		unique case (next_addr)
			NCP_REG_IFSETUP: rd_val = interface_setup;
			NCP_REG_UPTR_LO: rd_val = uptr[7:0];
			NCP_REG_UPTR_HI: rd_val = uptr[15:8];
			NCP_REG_UDATA: rd_val =
				(uptr == NCP_CHIRP_ADDR) ? chirp_control : 8'h00;
			default: rd_val = 8'h00;
		endcase
	end
	// next values of the answer path
	always_comb begin
		next_rd_busy = rd_busy;
		next_gap = 1'b0;
		next_shown = shown;
		next_dout = shared_data_bus_out;
		next_pend = (pend & ~(rd_take ? shown : 6'h00)) |
			{source_events, enum_ev}; // R11
		if (rd_take && shown != '0) begin
			next_shown = '0;
			next_gap = 1'b1;
		end
		if (rd_req) begin
			next_rd_busy = 1'b1; // R11
			next_shown = '0;
			next_dout = rd_val; // R10
		end else if (rd_busy && rd_take) begin
			next_rd_busy = 1'b0; // R23
			next_gap = 1'b1; // R23
		end else if (!rd_busy && !gap && shown == '0 && pend != '0) begin
			next_shown = pend; // R23
			next_dout = {2'b00, pend};
		end
		next_int_n = !(next_rd_busy || next_shown != '0); // R10
	end
	// answer registers
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			pend <= '0;
			shown <= '0;
			rd_busy <= 1'b0;
			gap <= 1'b0;
			shared_data_bus_out <= 8'h00;
			int_n <= 1'b1;
			shared_data_bus_oe <= 1'b0;
		end else begin
			pend <= next_pend;
			shown <= next_shown;
			rd_busy <= next_rd_busy;
			gap <= next_gap;
			shared_data_bus_out <= next_dout;
			int_n <= next_int_n;
			shared_data_bus_oe <= sel_cmd && !oe_s;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// enumeration: detach, parse, reattach, report
	logic [NCP_TMR_W-1:0] tmr, next_tmr;
	logic [15:0] ptr, next_ptr;       // parse walk position
	logic [7:0]  next_count;
	logic        next_default;
	assign mem_raddr = NCP_MEM_AW'(ptr);
	always_comb begin
		next_en_state = en_state;
		next_tmr = tmr;
		next_ptr = ptr;
		next_count = descriptor_count;
		next_default = default_descriptor;
		enum_ev = 1'b0;
		unique case (en_state)
			ncp_en_idle: begin
				if (load_done) begin
					next_en_state = ncp_en_detach; // R14
					next_tmr = NCP_TMR_W'(NCP_DETACH_CYC);
					next_ptr = '0;
					next_count = '0;
					next_default = (desc_len == NCP_DEFAULT_LEN); // R20
				end
			end
			ncp_en_detach: begin
				next_tmr = tmr - 1'b1;
				if (tmr == '0) begin
					// built-in descriptor needs no walk
					next_en_state = default_descriptor ?
						ncp_en_attach : ncp_en_parse; // R20
					next_tmr = NCP_TMR_W'(NCP_DETACH_CYC);
				end
			end
			ncp_en_parse: begin
				// each descriptor starts with its own length byte
				if (ptr >= desc_len || mem_rdata == 8'h00) begin // R14
					next_en_state = ncp_en_attach;
				end else begin
					next_ptr = ptr + {8'h00, mem_rdata};
					next_count = descriptor_count + 8'h01;
				end
			end
			ncp_en_attach: begin
				next_tmr = tmr - 1'b1;
				if (tmr == '0) begin
					next_en_state = ncp_en_run;
					enum_ev = 1'b1; // R15
				end
			end
			ncp_en_run: begin
			end
		endcase
	end
	// enumeration registers
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			en_state <= ncp_en_idle;
			tmr <= '0;
			ptr <= '0;
			descriptor_count <= '0;
			default_descriptor <= 1'b0;
			dplus_pullup_en <= 1'b0;
			full_speed_only <= 1'b0;
		end else begin
			en_state <= next_en_state;
			tmr <= next_tmr;
			ptr <= next_ptr;
			descriptor_count <= next_count;
			default_descriptor <= next_default;
			dplus_pullup_en <= (next_en_state == ncp_en_attach) ||
				(next_en_state == ncp_en_run); // R14
			full_speed_only <= chirp_control[NCP_CHIRP_FS]; // R17
		end
	end
	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	property p_ready_drop;
		byte_take |=> !ready [*3];
	endproperty
	a_ready_drop: assert property (p_ready_drop) // R8
		else $error("ready not held low after a byte");
	property p_ready_back;
		byte_take |-> ##[1:6] ready;
	endproperty
	a_ready_back: assert property (p_ready_back) // R8
		else $error("ready did not return");
	property p_addr_restart;
		byte_take && rx[NCP_ADDR_BIT] && !rx[NCP_RD_BIT]
		|=> state == ncp_hi && hi_nib == 0;
	endproperty
	a_addr_restart: assert property (p_addr_restart) // R3
		else $error("write address did not restart the pair");
	property p_ifsetup_write;
		byte_take && !rx[NCP_ADDR_BIT] && state == ncp_lo &&
		addr == NCP_REG_IFSETUP
		|=> interface_setup == {$past(hi_nib), $past(rx[3:0])};
	endproperty
	a_ifsetup_write: assert property (p_ifsetup_write) // R9
		else $error("assembled byte not stored");
	property p_series;
		byte_take && !rx[NCP_ADDR_BIT] && state == ncp_lo |=> state == ncp_hi;
	endproperty
	a_series: assert property (p_series) // R6
		else $error("series byte did not restart the pair");
	property p_read_int;
		rd_req |=> !int_n && shared_data_bus_out == $past(rd_val);
	endproperty
	a_read_int: assert property (p_read_int) // R10
		else $error("read answer missing");
	property p_read_hold;
		rd_busy |-> shown == 0;
	endproperty
	a_read_hold: assert property (p_read_hold) // R11
		else $error("event shown during a read");
	property p_release;
		rd_busy && rd_take && !rd_req |=> ##1 int_n;
	endproperty
	a_release: assert property (p_release) // R23
		else $error("interrupt not released after read");
	property p_pullup;
		en_state == ncp_en_detach |-> !dplus_pullup_en;
	endproperty
	a_pullup: assert property (p_pullup) // R14
		else $error("pull-up connected while detached");
	property p_enum_ev;
		enum_ev |=> pend[NCP_EV_ENUM] || shown[NCP_EV_ENUM];
	endproperty
	a_enum_ev: assert property (p_enum_ev) // R15
		else $error("enumeration done event lost");
	property p_chirp;
		chirp_control[NCP_CHIRP_FS] |=> full_speed_only;
	endproperty
	a_chirp: assert property (p_chirp) // R17
		else $error("full speed only not applied");
	c_write: cover property (byte_take && state == ncp_lo);
	c_read: cover property (rd_req ##[1:20] rd_take);
	c_enum: cover property (enum_ev);
endmodule
`default_nettype wire

// file: tb/ncp_master.sv
// behavioural model of the external master on the command port
`timescale 1ns/10ps
`default_nettype none
module ncp_master
	import ncp_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       ready,
	input  wire logic       int_n,
	input  wire logic [7:0] shared_data_bus_out,
	input  wire logic       shared_data_bus_oe,
	output logic      [2:0] port_select_lines,
	output logic            wr_strobe_n,
	output logic            rd_strobe_n,
	output logic            out_enable_n,
	output logic      [7:0] shared_data_bus_in
);
	////////////////////////////////////////////////////////////////////////
	// idle levels from time zero, command port kept selected
	initial begin
		port_select_lines  = NCP_SEL_CMD;
		wr_strobe_n        = 1'b1;
		rd_strobe_n        = 1'b1;
		out_enable_n       = 1'b1;
		shared_data_bus_in = 8'h5a;
	end

	////////////////////////////////////////////////////////////////////////
	// one byte: wait for ready, strobe, hold until ready drops
	// lowc counts the sampled cycles with ready low afterwards
	task automatic put_byte(input logic [7:0] b, output int lowc);
		int n;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (ready !== 1'b1 && n < 200);
		wr_strobe_n        <= 1'b0;
		shared_data_bus_in <= b;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (ready !== 1'b0 && n < 20);
		// released bus shows the inverse so a stale byte never passes
		wr_strobe_n        <= 1'b1;
		shared_data_bus_in <= ~b;
		lowc = 0;
		while (ready === 1'b0 && lowc < 20) begin
			lowc++;
			@(posedge ref_clk);
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	// take one answer: enable the bus, wait for int_n, strobe read
	// the oe pin lags by three cycles, so sampling waits four edges
	task automatic get_ans(output logic [7:0] d, output logic oe);
		int n;
		// one edge first: a release just made is never overwritten
		@(posedge ref_clk);
		out_enable_n <= 1'b0;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (int_n !== 1'b0 && n < 1500);
		repeat (4) @(posedge ref_clk);
		d  = shared_data_bus_out;
		oe = shared_data_bus_oe;
		rd_strobe_n <= 1'b0;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (int_n !== 1'b1 && n < 20);
		rd_strobe_n  <= 1'b1;
		out_enable_n <= 1'b1;
	endtask
endmodule
`default_nettype wire

// file: tb/tb.sv
// self-checking bench for the nibble command port
`timescale 1ns/10ps
`default_nettype none
module tb
	import ncp_pkg::*;
;
	logic       ref_clk;             // 40 MHz clock
	logic       nrst;                // async reset, active low
	logic [4:0] source_events;       // event pulses into the port
	logic [2:0] port_select_lines;   // from the master model
	logic       wr_strobe_n;
	logic       rd_strobe_n;
	logic       out_enable_n;
	logic [7:0] shared_data_bus_in;
	logic [7:0] shared_data_bus_out; // from the design
	logic       shared_data_bus_oe;
	logic       ready;
	logic       int_n;
	logic       dplus_pullup_en;
	logic       full_speed_only;
	logic       default_descriptor;
	logic [7:0] interface_setup;
	logic [7:0] descriptor_count;    // descriptors found by the walk
	int         err_count;           // mismatches seen
	int         checked;             // comparisons made
	int         seed;                // fixed seed keeps runs repeatable

	ncp_top dut (
		.ref_clk(ref_clk), .nrst(nrst),
		.port_select_lines(port_select_lines),
		.wr_strobe_n(wr_strobe_n), .rd_strobe_n(rd_strobe_n),
		.out_enable_n(out_enable_n),
		.shared_data_bus_in(shared_data_bus_in),
		.source_events(source_events),
		.shared_data_bus_out(shared_data_bus_out),
		.shared_data_bus_oe(shared_data_bus_oe),
		.ready(ready), .int_n(int_n),
		.dplus_pullup_en(dplus_pullup_en),
		.full_speed_only(full_speed_only),
		.default_descriptor(default_descriptor),
		.interface_setup(interface_setup),
		.descriptor_count(descriptor_count)
	);

	ncp_master m (
		.ref_clk(ref_clk), .ready(ready), .int_n(int_n),
		.shared_data_bus_out(shared_data_bus_out),
		.shared_data_bus_oe(shared_data_bus_oe),
		.port_select_lines(port_select_lines),
		.wr_strobe_n(wr_strobe_n), .rd_strobe_n(rd_strobe_n),
		.out_enable_n(out_enable_n),
		.shared_data_bus_in(shared_data_bus_in)
	);

	////////////////////////////////////////////////////////////////////////
	// clock generator
	always #(NCP_CLK_NS / 2.0) ref_clk = ~ref_clk;

	////////////////////////////////////////////////////////////////////////
	// comparison, verdict and byte builders
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// address byte: marker, direction, register number
	function automatic logic [7:0] addr_b(logic rd, logic [5:0] r);
		return {1'b1, rd, r};
	endfunction

	// data byte: marker clear, don't care bits random, one nibble
	function automatic logic [7:0] nib_b(logic [3:0] n);
		return {1'b0, 3'($random(seed)), n};
	endfunction

	// every byte checks that ready holds off for the hold time
	task automatic send(input logic [7:0] b);
		int lowc;
		m.put_byte(b, lowc);
		check(8'(lowc), 8'(NCP_HOLD_CYC));
	endtask

	task automatic wr_pair(input logic [7:0] v);
		send(nib_b(v[7:4]));
		send(nib_b(v[3:0]));
	endtask

	task automatic wr_reg(input logic [5:0] r, input logic [7:0] v);
		send(addr_b(1'b0, r));
		wr_pair(v);
	endtask

	task automatic rd_reg(input logic [5:0] r, output logic [7:0] d,
		output logic oe);
		send(addr_b(1'b1, r));
		m.get_ans(d, oe);
	endtask

	// descriptor lengths in order: device, qualifier, high-speed
	// configuration, interface, endpoint, full-speed set, string
	function automatic logic [7:0] dlen(input int k);
		logic [7:0] l [9];
		l = '{8'h12, 8'h0a, 8'h09, 8'h09, 8'h07,
			8'h09, 8'h09, 8'h07, 8'h04};
		return l[k];
	endfunction

	// wait for the pull-up, then expect the enumeration done event
	task automatic wait_enum(input logic dflt, input logic [7:0] cnt);
		int         n;
		logic [7:0] d;
		logic       oe;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (dplus_pullup_en !== 1'b1 && n < 1200);
		check(8'(n > 380 && n < 1200), 8'h01);
		check({7'h00, default_descriptor}, {7'h00, dflt});
		check(descriptor_count, cnt);
		m.get_ans(d, oe);
		check(d, 8'h01);
	endtask

	////////////////////////////////////////////////////////////////////////
	// watchdog: far beyond the few thousand cycles the tests need
	initial begin
		#(NCP_CLK_NS * 20000);
		err_count++;
		final_report();
	end

	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		logic [7:0] d;
		logic [7:0] v;
		logic [4:0] ev;
		logic       oe;
		int         tot;
		ref_clk = 1'b0;
		nrst = 1'b0;
		source_events = 5'h00;
		err_count = 0;
		checked = 0;
		seed = 34;
		repeat (10) @(posedge ref_clk);
		check(interface_setup, NCP_IFSETUP_RST);
		check({6'h00, full_speed_only, int_n}, 8'h01);
		check({7'h00, dplus_pullup_en}, 8'h00);
		nrst <= 1'b1;
		$display("test reset done");

		// plain example value, then random values read back
		wr_reg(NCP_REG_IFSETUP, 8'hb0);
		check(interface_setup, 8'hb0);
		for (int i = 0; i < 6; i++) begin
			v = 8'($random(seed));
			wr_reg(NCP_REG_IFSETUP, v);
			check(interface_setup, v);
			rd_reg(NCP_REG_IFSETUP, d, oe);
			check(d, v);
			check({7'h00, oe}, 8'h01);
		end
		$display("test write and read done");

		// half a pair dropped by a new address, unmapped write ignored
		send(addr_b(1'b0, NCP_REG_IFSETUP));
		send(nib_b(4'h5));
		wr_reg(NCP_REG_IFSETUP, 8'ha3);
		check(interface_setup, 8'ha3);
		wr_reg(6'h05, 8'h3c);
		check(interface_setup, 8'ha3);
		$display("test discard done");

		// unindexed pointer, then chirp value through the data register
		wr_reg(NCP_REG_UPTR_LO, NCP_CHIRP_ADDR[7:0]);
		wr_reg(NCP_REG_UPTR_HI, NCP_CHIRP_ADDR[15:8]);
		rd_reg(NCP_REG_UPTR_LO, d, oe);
		check(d, NCP_CHIRP_ADDR[7:0]);
		check({7'h00, full_speed_only}, 8'h00);
		wr_reg(NCP_REG_UDATA, 8'h02);
		check({7'h00, full_speed_only}, 8'h01);
		rd_reg(NCP_REG_UDATA, d, oe);
		check(d, 8'h02);
		$display("test unindexed done");

		// events arriving during a read wait until it is taken
		ev = 5'($random(seed)) | 5'h01;
		send(addr_b(1'b1, NCP_REG_IFSETUP));
		@(posedge ref_clk) source_events <= ev;
		@(posedge ref_clk) source_events <= 5'h00;
		m.get_ans(d, oe);
		check(d, 8'ha3);
		m.get_ans(d, oe);
		check(d, {2'b00, ev, 1'b0});
		repeat (8) @(posedge ref_clk);
		check({7'h00, int_n}, 8'h01);
		$display("test events done");

		// default descriptor: length six, then six identifier bytes
		send(addr_b(1'b0, NCP_REG_DESC));
		wr_pair(NCP_DEFAULT_LEN[7:0]);
		wr_pair(NCP_DEFAULT_LEN[15:8]);
		for (int i = 0; i < 6; i++) begin
			wr_pair(8'($random(seed)));
		end
		wait_enum(1'b1, 8'h00);
		$display("test enumeration done");

		// mid-run reset, then an ordered descriptor set for the walk
		@(posedge ref_clk) nrst <= 1'b0;
		repeat (3) @(posedge ref_clk);
		check({5'h00, dplus_pullup_en, ready, int_n}, 8'h01);
		nrst <= 1'b1;
		tot = 0;
		for (int k = 0; k < 9; k++) begin
			tot += dlen(k);
		end
		send(addr_b(1'b0, NCP_REG_DESC));
		wr_pair(8'(tot));
		wr_pair(8'(tot >> 8));
		for (int k = 0; k < 9; k++) begin
			wr_pair(dlen(k));
			for (int j = 1; j < int'(dlen(k)); j++) begin
				wr_pair(8'($random(seed)));
			end
		end
		wait_enum(1'b0, 8'h09);
		$display("test descriptor walk done");
		final_report();
	end
endmodule
`default_nettype wire
